/* File: verif/testbench.sv */
module testbench
    import rss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic        clk_i;
    logic        srst_i;
    logic        ext_reset_i;
    logic        timed_access_i;
    logic        hsel_i;
    logic [31:0] haddr_i;
    logic [1:0]  htrans_i;
    logic        hwrite_i;
    logic [2:0]  hsize_i;
    logic [31:0] hwdata_i;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp_o;
    logic        sys_reset_o;
    logic [15:0] pc_o;
    logic        boot_loader_o;
    logic [7:0]  stack_init_o;
    logic [7:0]  port_latch_o;
    logic        ram_retained_o;
    logic        dog_expired_o;
    logic [31:0] r;
    logic [7:0]  aux_exp;
    logic        seen;
    int          errors;
    int          n_tests;
    int          seed;

    // Short watchdog count keeps the run brief
    rss_top #(.DOG_W(20), .DOG_BASE(1)) DUT (
        .clk_i(clk_i), .srst_i(srst_i), .ext_reset_i(ext_reset_i),
        .timed_access_i(timed_access_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .sys_reset_o(sys_reset_o), .pc_o(pc_o),
        .boot_loader_o(boot_loader_o), .stack_init_o(stack_init_o),
        .port_latch_o(port_latch_o), .ram_retained_o(ram_retained_o),
        .dog_expired_o(dog_expired_o));

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ==========================================================
    // Checks and bus cycles
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Unlock is only presented in the data phase, as the block samples it
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, input logic ta);
        hsel_i   <= 1'b1;
        haddr_i  <= a;
        htrans_i <= 2'b10;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i       <= 2'b00;
        hwdata_i       <= d;
        timed_access_i <= ta;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
        timed_access_i <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [31:0] a,
                      input logic [7:0] e);
        xfer(a, 1'b0, 32'h0, 1'b0);
        chk(nm, {24'h0, e}, r);
    endtask

    task automatic wait_rel();
        int i;
        for (i = 0; i < 100 && sys_reset_o !== 1'b0; i++)
            @(posedge clk_i);
        chk("reset released", 1'b0, sys_reset_o);
    endtask

    task automatic ext_pulse();
        ext_reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("pc in reset", PC_RESET, pc_o);
        ext_reset_i <= 1'b0;
        @(posedge clk_i);
        wait_rel();
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        seed = 33;
        {srst_i, ext_reset_i, timed_access_i, hsel_i} = 4'b1000;
        {haddr_i, htrans_i, hwrite_i, hwdata_i} = '0;
        hsize_i = 3'h2;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        wait_rel();
        chk("stack", SP_RESET, stack_init_o);
        chk("port", PORT_RESET, port_latch_o);
        chk("boot", 1'b0, boot_loader_o);
        chk("ram kept", 1'b0, ram_retained_o);
        chk("resp", 1'b0, hresp_o);
        chk("ready", 1'b1, hreadyout_o);
        rd("chip", ADDR_CHIP, 8'h00);
        rd("aux", ADDR_AUX, 8'h00);
        rd("dog", ADDR_DOG, DOG_POR);
        rd("cfg", ADDR_CFG, CFG_POR);
        rd("unmapped", 32'h0000_0010, 8'h00);
        $display("test reset values done");

        xfer(ADDR_CHIP, 1'b1, 32'h80, 1'b0);
        repeat (3) @(posedge clk_i);
        chk("locked trigger", 1'b0, sys_reset_o);
        repeat (4)
        begin
            aux_exp = $random(seed);
            xfer(ADDR_AUX, 1'b1, {24'h0, aux_exp}, 1'b0);
            aux_exp = {aux_exp[7], 7'h0};
            rd("aux rw", ADDR_AUX, aux_exp);
        end
        $display("test protection done");

        xfer(ADDR_CFG, 1'b1, 32'h7f, 1'b1);
        ext_pulse();
        chk("boot loader", 1'b1, boot_loader_o);
        chk("ram kept", 1'b1, ram_retained_o);
        rd("chip boot", ADDR_CHIP, 8'h02);
        rd("aux kept", ADDR_AUX, aux_exp);
        $display("test config boot done");

        // Config bit back to one: a reload would now pick application
        xfer(ADDR_CFG, 1'b1, 32'hff, 1'b1);
        xfer(ADDR_AUX, 1'b1, 32'h0, 1'b0);
        xfer(ADDR_CHIP, 1'b1, 32'h82, 1'b1);
        repeat (2) @(posedge clk_i);
        chk("soft reset", 1'b1, sys_reset_o);
        wait_rel();
        rd("soft flag", ADDR_AUX, 8'h80);
        rd("trigger", ADDR_CHIP, 8'h02);
        chk("boot kept", 1'b1, boot_loader_o);
        rd("dog other", ADDR_DOG, 8'h07);
        $display("test soft reset done");

        seen = 1'b0;
        xfer(ADDR_DOG, 1'b1, 32'h87, 1'b1);
        repeat (100)
        begin
            xfer(ADDR_DOG, 1'b1, 32'hc7, 1'b1);
            seen = seen | sys_reset_o;
        end
        chk("restart", 1'b0, seen);
        xfer(ADDR_DOG, 1'b1, 32'h81, 1'b1);
        for (int i = 0; i < 200 && sys_reset_o !== 1'b1; i++)
        begin
            @(posedge clk_i);
            seen = seen | dog_expired_o;
        end
        chk("expiry seen", 1'b1, seen);
        chk("dog reset", 1'b1, sys_reset_o);
        wait_rel();
        chk("pc", PC_RESET, pc_o);
        rd("dog flag", ADDR_DOG, 8'h09);
        chk("boot reload", 1'b0, boot_loader_o);
        rd("soft kept", ADDR_AUX, 8'h80);
        ext_pulse();
        rd("dog kept", ADDR_DOG, 8'h09);
        xfer(ADDR_DOG, 1'b1, 32'h01, 1'b1);
        rd("dog clear", ADDR_DOG, 8'h01);
        $display("test watchdog done");
        complete_run();
    end

    initial
    begin
        #60000;
        errors++;
        complete_run();
    end
endmodule

/* File: verilog/rss_pkg.sv */
// Function
// - Watchdog expiry without restart resets the system; fetch restarts at zero.
// - Software may restart the watchdog count at any time.
// - Watchdog reset sets the watchdog reset flag, bit 3 of dog control.
// - Watchdog flag survives other resets; power-on clears it, watchdog sets it.
// - Dog control: 07 on power-on, 00001UUU on watchdog, 0000UUUU otherwise.
// - Writing one to bit 7 of chip control resets the system.
// - The trigger write is the last instruction before reset.
// - The trigger is write-only and self-clears when reset finishes.
// - Software reset sets bit 7 of the auxiliary flags register.
// - Soft flag survives other resets, cleared by power-on or software write.
// - Chip control resets to zero except boot select.
// - Boot select 0 fetches the application block, 1 the loader block.
// - Non-software resets load boot select with inverted config bit 7.
// - After reset the boot block comes only from boot select.
// - Config boot bit 1 selects application; config byte defaults to ff.
// - RAM is kept over every reset except power-on.
// - Program counter is forced to zero while reset is held.
// - Every reset loads the stack pointer with 07.
// - Reset disables peripherals; port latches become ff, pins input-only.
package rss_pkg;

    // ==========================================================
    // Register map (index, byte address is four times it)
    localparam logic [7:0]  IDX_CHIP  = 8'h9f;
    localparam logic [7:0]  IDX_AUX   = 8'ha2;
    localparam logic [7:0]  IDX_DOG   = 8'haa;
    localparam logic [7:0]  IDX_CFG   = 8'hb0;
    localparam logic [31:0] ADDR_CHIP = {22'h0, IDX_CHIP, 2'h0};
    localparam logic [31:0] ADDR_AUX  = {22'h0, IDX_AUX, 2'h0};
    localparam logic [31:0] ADDR_DOG  = {22'h0, IDX_DOG, 2'h0};
    localparam logic [31:0] ADDR_CFG  = {22'h0, IDX_CFG, 2'h0};

    // ==========================================================
    // Field positions
    localparam int DOG_RUN_BIT   = 7;
    localparam int DOG_CLR_BIT   = 6;
    localparam int DOG_TOF_BIT   = 5;
    localparam int DOG_FLAG_BIT  = 3;
    localparam int SOFT_TRIG_BIT = 7;
    localparam int CHIP_KEEP6    = 6;
    localparam int BOOT_SEL_BIT  = 1;
    localparam int CHIP_KEEP0    = 0;
    localparam int SOFT_FLAG_BIT = 7;
    localparam int CFG_BOOT_BIT  = 7;

    // ==========================================================
    // Reset values and counts
    localparam logic [7:0]  DOG_POR    = 8'h07;
    localparam logic [7:0]  CFG_POR    = 8'hff;
    localparam logic [7:0]  SP_RESET   = 8'h07;
    localparam logic [7:0]  PORT_RESET = 8'hff;
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam logic [3:0]  HOLD_CYC   = 4'h8;
    localparam logic [3:0]  DOG_GRACE  = 4'h8;

    typedef enum logic [1:0]
    {
        RSS_RUN  = 2'b01,
        RSS_HOLD = 2'b10
    } rss_state_t;

endpackage

/* File: verilog/rss_top.sv */
// Decided for this implementation: the AHB-Lite interface to the registers.
module rss_top
    import rss_pkg::*;
#(
    parameter int DOG_W    = 20,
    parameter int DOG_BASE = 6
)
(
    input  wire logic        clk_i,           // System clock
    input  wire logic        srst_i,          // Power-on reset
    input  wire logic        ext_reset_i,     // Other reset source, level
    input  wire logic        timed_access_i,  // Unlock sequence satisfied
    input  wire logic        hsel_i,          // AHB select
    input  wire logic [31:0] haddr_i,         // AHB address
    input  wire logic [1:0]  htrans_i,        // AHB transfer type
    input  wire logic        hwrite_i,        // AHB write
    input  wire logic [2:0]  hsize_i,         // AHB size
    input  wire logic [31:0] hwdata_i,        // AHB write data
    input  wire logic        hready_i,        // AHB bus ready
    output logic      [31:0] hrdata_o,        // AHB read data
    output logic             hreadyout_o,     // AHB slave ready
    output logic             hresp_o,         // AHB response
    output logic             sys_reset_o,     // Whole-system reset
    output logic      [15:0] pc_o,            // Fetch address at release
    output logic             boot_loader_o,   // 1: loader, 0: application
    output logic      [7:0]  stack_init_o,    // Stack pointer load value
    output logic      [7:0]  port_latch_o,    // Port latch reset value
    output logic             ram_retained_o,  // Last reset kept RAM
    output logic             dog_expired_o    // Watchdog time-out seen
);

    initial
    begin
        if (DOG_BASE < 1 || DOG_BASE + 7 >= DOG_W)
            $error("rss_top: DOG_BASE does not fit DOG_W");
    end

    // ==========================================================
    // State
    rss_state_t        state;
    rss_state_t        next_state;
    logic [3:0]        hold_cnt;
    logic [7:0]        dog_ctrl;
    logic [7:0]        chip_ctl;
    logic              soft_pend;
    logic              soft_flag;
    logic [7:0]        cfg_byte;
    logic [DOG_W-1:0]  dog_cnt;
    logic [3:0]        grace_cnt;
    logic              dog_tout;
    logic              dp_wr;
    logic [31:0]       dp_addr;

    // ==========================================================
    // AHB decode
    wire        ap_go   = hsel_i & htrans_i[1] & hready_i;
    wire        wr_ok   = dp_wr & timed_access_i;
    wire        wr_dog  = wr_ok & (dp_addr == ADDR_DOG);
    wire        wr_chip = wr_ok & (dp_addr == ADDR_CHIP);
    wire        wr_cfg  = wr_ok & (dp_addr == ADDR_CFG);
    wire        wr_aux  = dp_wr & (dp_addr == ADDR_AUX);
    wire [7:0]  wd      = hwdata_i[7:0];
    wire        running = (state == RSS_RUN);

    wire [7:0] rd_mux =
        (haddr_i == ADDR_DOG)  ? dog_ctrl :
        (haddr_i == ADDR_CHIP) ? {1'b0, chip_ctl[6:0]} :
        (haddr_i == ADDR_AUX)  ? {soft_flag, 7'h00} :
        (haddr_i == ADDR_CFG)  ? cfg_byte : 8'h00;

    // ==========================================================
    // Reset sources and cause
    wire [4:0] dog_sel  = 5'(DOG_BASE) + {2'b00, dog_ctrl[2:0]};
    wire       dog_clr  = wr_dog & wd[DOG_CLR_BIT];
    wire       dog_run  = dog_ctrl[DOG_RUN_BIT];
    wire       dog_hit  = dog_run & dog_cnt[dog_sel] & ~dog_tout;
    wire       dog_fire = dog_tout & (grace_cnt == 4'h0) & ~dog_clr;
    wire       sw_go    = wr_chip & wd[SOFT_TRIG_BIT] & running;
    wire       enter    = running & (ext_reset_i | dog_fire | sw_go);
    wire       is_dog   = dog_fire & ~ext_reset_i;
    wire       is_sw    = sw_go & ~ext_reset_i & ~dog_fire;
    wire       hold_end = (hold_cnt == 4'h0) & ~ext_reset_i;

    always_comb
    begin
        next_state = state;
        case (state)
            RSS_RUN:
                if (enter)
                    next_state = RSS_HOLD;
            RSS_HOLD:
                if (hold_end)
                    next_state = RSS_RUN;
            default:
                next_state = RSS_HOLD;
        endcase
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state    <= RSS_HOLD;
            hold_cnt <= HOLD_CYC - 4'h1;
        end
        else
        begin
            state <= next_state;
            if (enter)
                hold_cnt <= HOLD_CYC - 4'h1;
            else if (hold_cnt != 4'h0)
                hold_cnt <= hold_cnt - 4'h1;
        end
    end

    // Trigger stays set through the reset and drops as it ends
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            soft_pend <= 1'b0;
        else if (sw_go)
            soft_pend <= 1'b1;
        else if (!running && hold_end)
            soft_pend <= 1'b0;
    end

    // ==========================================================
    // Watchdog counter
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !running || dog_clr || !dog_run)
        begin
            dog_cnt   <= '0;
            dog_tout  <= 1'b0;
            grace_cnt <= DOG_GRACE;
        end
        else
        begin
            dog_cnt <= dog_cnt + 1'b1;
            if (dog_hit)
                dog_tout <= 1'b1;
            if (dog_tout && grace_cnt != 4'h0)
                grace_cnt <= grace_cnt - 4'h1;
        end
    end

    // ==========================================================
    // Watchdog control; reset entry overrides a same-cycle write
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            dog_ctrl <= DOG_POR;
        else
        begin
            if (wr_dog && running)
                dog_ctrl <= {wd[7], 1'b0, wd[5:0]};
            if (dog_hit)
                dog_ctrl[DOG_TOF_BIT] <= 1'b1;
            if (enter && is_dog)
                dog_ctrl <= {5'b00001, dog_ctrl[2:0]};
            else if (enter)
                dog_ctrl <= {4'h0, dog_ctrl[3:0]};
        end
    end

    // ==========================================================
    // Chip control, boot select and soft flag
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            chip_ctl <= {6'h00, ~CFG_POR[CFG_BOOT_BIT], 1'b0};
        else if (enter && is_sw)
            chip_ctl <= {6'h00, chip_ctl[BOOT_SEL_BIT], 1'b0};
        else if (enter)
            chip_ctl <= {6'h00, ~cfg_byte[CFG_BOOT_BIT], 1'b0};
        else if (wr_chip && running)
        begin
            chip_ctl[CHIP_KEEP6]   <= wd[CHIP_KEEP6];
            chip_ctl[BOOT_SEL_BIT] <= wd[BOOT_SEL_BIT];
            chip_ctl[CHIP_KEEP0]   <= wd[CHIP_KEEP0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            soft_flag <= 1'b0;
        else if (enter && is_sw)
            soft_flag <= 1'b1;
        else if (wr_aux && running)
            soft_flag <= wd[SOFT_FLAG_BIT];
    end

    // Config byte stands in for the flash copy
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            cfg_byte <= CFG_POR;
        else if (wr_cfg && running)
            cfg_byte <= wd;
    end

    // ==========================================================
    // AHB slave: zero wait, read data captured in address phase
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            dp_wr       <= 1'b0;
            dp_addr     <= '0;
            hrdata_o    <= '0;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            dp_wr <= ap_go & hwrite_i & (hsize_i == 3'h2);
            if (ap_go)
                dp_addr <= haddr_i;
            if (ap_go && !hwrite_i)
                hrdata_o <= {24'h0, rd_mux};
        end
    end

    // ==========================================================
    // System-facing outputs
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sys_reset_o    <= 1'b1;
            pc_o           <= PC_RESET;
            boot_loader_o  <= ~CFG_POR[CFG_BOOT_BIT];
            stack_init_o   <= SP_RESET;
            port_latch_o   <= PORT_RESET;
            ram_retained_o <= 1'b0;
            dog_expired_o  <= 1'b0;
        end
        else
        begin
            sys_reset_o   <= (next_state == RSS_HOLD);
            pc_o          <= PC_RESET;
            boot_loader_o <= chip_ctl[BOOT_SEL_BIT];
            stack_init_o  <= SP_RESET;
            port_latch_o  <= PORT_RESET;
            if (enter)
                ram_retained_o <= 1'b1;
            dog_expired_o <= dog_tout;
        end
    end

    // ==========================================================
    // Checks
    soft_next_a: assert property (@(posedge clk_i) disable iff (srst_i)
        sw_go |=> sys_reset_o)
        else $error("soft trigger did not reset next cycle");

    hold_len_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(sys_reset_o) |-> sys_reset_o [*8])
        else $error("reset held too short");

    dog_flag_a: assert property (@(posedge clk_i) disable iff (srst_i)
        enter && is_dog |=> dog_ctrl[7:3] == 5'b00001)
        else $error("watchdog flag not set");

    soft_flag_a: assert property (@(posedge clk_i) disable iff (srst_i)
        enter && is_sw |=> soft_flag)
        else $error("soft flag not set");

    boot_keep_a: assert property (@(posedge clk_i) disable iff (srst_i)
        enter && is_sw |=> $stable(chip_ctl[BOOT_SEL_BIT]))
        else $error("boot select changed on soft reset");

    boot_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
        enter && !is_sw |=>
        chip_ctl[BOOT_SEL_BIT] == ~$past(cfg_byte[CFG_BOOT_BIT]))
        else $error("boot select not loaded from config");

    trig_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(sys_reset_o) |-> !soft_pend)
        else $error("soft trigger not cleared after reset");

    locked_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        dp_wr && !timed_access_i && !enter && !dog_hit
        |=> $stable(dog_ctrl))
        else $error("protected write without unlock");

    dog_restart_a: assert property (@(posedge clk_i) disable iff (srst_i)
        dog_clr |=> dog_cnt == '0)
        else $error("watchdog not restarted");

    boot_out_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(sys_reset_o) |->
        boot_loader_o == $past(chip_ctl[BOOT_SEL_BIT]))
        else $error("boot output not from boot select");

endmodule
